// ==== design/rss_pkg.sv ====
package rss_pkg;

    // ************************************************************
    // Timing constants
    // ************************************************************

    // Clock period in picoseconds (250 MHz).
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Stabilisation delay for RC oscillator or external clock, in CPU cycles.
    localparam int unsigned STAB_SHORT_CYC = 256;
    // Stabilisation delay for crystal or ceramic resonator, in CPU cycles.
    localparam int unsigned STAB_LONG_CYC = 4096;
    // Length of the vector fetch phase in cycles.
    localparam int unsigned FETCH_CYC = 2;
    // Least width of the driven reset output pulse, in nanoseconds.
    localparam int unsigned MIN_RESET_OUT_PULSE_NS = 20;
    // Same width as a count of clock cycles, rounded up.
    localparam int unsigned MIN_RESET_OUT_PULSE_CYC =
        (MIN_RESET_OUT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Extra startup time of the PLL, in nanoseconds.
    localparam int unsigned PLL_STARTUP_DELAY_NS = 2000;
    // Same time as a count of clock cycles, rounded up.
    localparam int unsigned PLL_STARTUP_DELAY_CYC =
        (PLL_STARTUP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Width of the sequence delay counter.
    localparam int unsigned DLY_W = 13;

    // ************************************************************
    // Vector and reset values
    // ************************************************************

    // Address of the high byte of the reset vector.
    localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hFFFE;
    // Address of the low byte of the reset vector.
    localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hFFFF;
    // Flag values after reset.
    localparam logic FLAG_RST_VAL = 1'b0;
    // Bit positions of the status byte.
    localparam int unsigned ST_WDG_POS = 4;
    localparam int unsigned ST_LVR_POS = 2;
    localparam int unsigned ST_WARN_POS = 1;
    localparam int unsigned ST_IRQEN_POS = 0;

    // ************************************************************
    // Types
    // ************************************************************

    // Oscillator source chosen by configuration.
    typedef enum logic [1:0] {
        RSS_CLK_RC = 2'b00,
        RSS_CLK_EXT = 2'b01,
        RSS_CLK_XTAL = 2'b10
    } rss_clk_src_t;

    // Low voltage threshold level.
    typedef enum logic [1:0] {
        RSS_LV_LOW = 2'b00,
        RSS_LV_MED = 2'b01,
        RSS_LV_HIGH = 2'b10
    } rss_lv_level_t;

    // Reset sequence phases.
    typedef enum logic [2:0] {
        RSS_ST_RUN = 3'b000,
        RSS_ST_ACTIVE = 3'b001,
        RSS_ST_STAB = 3'b010,
        RSS_ST_PLL = 3'b011,
        RSS_ST_FETCH = 3'b100
    } rss_state_t;

endpackage

// ==== design/rss_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with asynchronous preset value.
module rss_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);

    // First stage, read only by the second.
    logic meta_reg;

    // ************************************************************
    // Synchroniser stages
    // ************************************************************

    // Two stages on the local clock.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= RST_VAL;
            q_out <= RST_VAL;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ==== design/rss_pin_catch.sv ====
`timescale 1ns/1ps
`default_nettype none
// Catches a low level on the reset pin without a clock and holds it.
module rss_pin_catch (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_n_in,
    input wire logic ack_in,
    output logic caught_out
);

    // Latched request, set asynchronously by the pin going low.
    logic hold_reg;
    // Synchronised copy of the latched request.
    logic sync_q;

    // ************************************************************
    // Asynchronous catch
    // ************************************************************

    // The pin low acts as an asynchronous set, so a stopped clock
    // does not stop detection; the clear needs a clock edge.
    always_ff @(posedge clk_in or posedge rst_in or negedge pin_n_in)
    begin
        if (rst_in)
        begin
            hold_reg <= 1'b0;
        end
        else if (!pin_n_in)
        begin
            hold_reg <= 1'b1;
        end
        else if (ack_in)
        begin
            hold_reg <= 1'b0;
        end
    end

    // Bring the caught request into the clock domain.
    rss_sync2 #(.RST_VAL(1'b0)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(hold_reg),
        .q_out(sync_q)
    );

    assign caught_out = sync_q;

endmodule
`default_nettype wire

// ==== design/rss_reset_sequence_manager.sv ====
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequence_manager
    import rss_pkg::*;
#(
    parameter int unsigned STAB_LONG = STAB_LONG_CYC,
    parameter int unsigned PLL_STARTUP = PLL_STARTUP_DELAY_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_n_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    input wire logic low_voltage_below_in,
    input wire logic warn_below_in,
    input wire logic lv_detector_en_in,
    input wire logic [1:0] lv_level_in,
    input wire logic [1:0] clk_src_in,
    input wire logic pll_en_in,
    input wire logic watchdog_underflow_in,
    input wire logic illegal_opcode_in,
    input wire logic halt_mode_in,
    input wire logic wait_mode_in,
    input wire logic cc_irq_mask_in,
    input wire logic irq_enable_wr_in,
    input wire logic irq_enable_data_in,
    input wire logic status_rd_in,
    input wire logic wdg_flag_wr0_in,
    input wire logic irq_ack_in,
    output logic [1:0] lv_level_out,
    output logic core_reset_out,
    output logic fetch_active_out,
    output logic [15:0] fetch_addr_out,
    output logic [7:0] status_out,
    output logic irq_out,
    output logic wake_out
);

    // ************************************************************
    // Declarations
    // ************************************************************

    // Sequence state and its next value.
    rss_state_t state_reg, state_next;
    // Phase delay counter.
    logic [DLY_W-1:0] dly_reg, dly_next;
    // Watchdog least-pulse counter.
    logic [DLY_W-1:0] wpulse_reg, wpulse_next;
    // Status flags.
    logic wdg_flag_reg, wdg_flag_next;
    logic lvr_flag_reg, lvr_flag_next;
    logic warn_flag_reg, warn_flag_next;
    logic irq_en_reg, irq_en_next;
    // Pending interrupt latch.
    logic pend_reg, pend_next;
    // Registered outputs.
    logic pin_oe_reg, pin_oe_next;
    logic core_rst_reg, core_rst_next;
    logic irq_reg, irq_next;
    logic wake_reg, wake_next;
    logic [15:0] faddr_reg, faddr_next;
    logic fa_reg, fa_next;
    // Synchronised analog comparator levels.
    logic lv_sync;
    logic warn_sync;
    // Pin request caught asynchronously.
    logic pin_req;
    // Combined request and source detail.
    logic lv_req;
    logic any_req;
    logic [DLY_W-1:0] stab_len;

    // ************************************************************
    // Input conditioning
    // ************************************************************

    // Low-voltage comparator level from the analog side.
    rss_sync2 #(.RST_VAL(1'b1)) u_lv_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(low_voltage_below_in),
        .q_out(lv_sync)
    );

    // Early-warning comparator level from the analog side.
    rss_sync2 #(.RST_VAL(1'b0)) u_warn_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(warn_below_in),
        .q_out(warn_sync)
    );

    // External pin catcher, released once the sequence has seen it.
    // The pin is masked while the core is held in reset, since the device's
    // own low drive would otherwise look like a fresh request forever.
    rss_pin_catch u_pin (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_n_in(reset_pin_n_in || core_rst_reg),
        .ack_in(pin_req && state_reg == RSS_ST_ACTIVE),
        .caught_out(pin_req)
    );

    // ************************************************************
    // Request combination
    // ************************************************************

    // Detector counts only when enabled; the outside circuit covers the
    // disabled case by holding the pin itself.
    assign lv_req = lv_detector_en_in && lv_sync;
    // All reset sources.
    assign any_req = pin_req || lv_req || watchdog_underflow_in
        || illegal_opcode_in;
    // Delay selected by oscillator source.
    assign stab_len = (clk_src_in == RSS_CLK_XTAL) ? DLY_W'(STAB_LONG)
        : DLY_W'(STAB_SHORT_CYC);

    // ************************************************************
    // Sequence next state
    // ************************************************************

    // Runs active, stabilisation, optional PLL wait and fetch.
    always_comb
    begin
        state_next = state_reg;
        dly_next = dly_reg;
        wpulse_next = wpulse_reg;
        faddr_next = faddr_reg;
        if (watchdog_underflow_in)
        begin
            wpulse_next = DLY_W'(MIN_RESET_OUT_PULSE_CYC);
        end
        else if (wpulse_reg != '0)
        begin
            wpulse_next = wpulse_reg - 1'b1;
        end
        case (state_reg)
            RSS_ST_RUN:
            begin
                if (any_req)
                begin
                    state_next = RSS_ST_ACTIVE;
                end
            end
            RSS_ST_ACTIVE:
            begin
                // Stay while a source still holds or the watchdog pulse count runs, then load the delay.
                if (!any_req && wpulse_reg == '0)
                begin
                    state_next = RSS_ST_STAB;
                    dly_next = stab_len - 1'b1;
                end
            end
            RSS_ST_STAB:
            begin
                if (any_req)
                begin
                    state_next = RSS_ST_ACTIVE;
                end
                else if (dly_reg == '0)
                begin
                    if (pll_en_in)
                    begin
                        state_next = RSS_ST_PLL;
                        dly_next = DLY_W'(PLL_STARTUP - 1);
                    end
                    else
                    begin
                        state_next = RSS_ST_FETCH;
                        dly_next = DLY_W'(FETCH_CYC - 1);
                        faddr_next = RESET_VEC_HI_ADDR;
                    end
                end
                else
                begin
                    dly_next = dly_reg - 1'b1;
                end
            end
            RSS_ST_PLL:
            begin
                if (any_req)
                begin
                    state_next = RSS_ST_ACTIVE;
                end
                else if (dly_reg == '0)
                begin
                    state_next = RSS_ST_FETCH;
                    dly_next = DLY_W'(FETCH_CYC - 1);
                    faddr_next = RESET_VEC_HI_ADDR;
                end
                else
                begin
                    dly_next = dly_reg - 1'b1;
                end
            end
            RSS_ST_FETCH:
            begin
                // Two cycles: high byte then low byte.
                if (dly_reg == '0)
                begin
                    state_next = RSS_ST_RUN;
                end
                else
                begin
                    dly_next = dly_reg - 1'b1;
                    faddr_next = RESET_VEC_LO_ADDR;
                end
            end
            default:
            begin
                state_next = RSS_ST_ACTIVE;
            end
        endcase
    end

    // ************************************************************
    // Output and flag next values
    // ************************************************************

    // Pin drive, core reset, status flags and interrupt.
    always_comb
    begin
        // Pin is driven low from active through the delay phases.
        pin_oe_next = (state_next == RSS_ST_ACTIVE) || (state_next == RSS_ST_STAB)
            || (state_next == RSS_ST_PLL);
        core_rst_next = (state_next != RSS_ST_RUN);
        // Fetch indication is registered so the output comes from a flop.
        fa_next = (state_next == RSS_ST_FETCH);
        wdg_flag_next = wdg_flag_reg;
        lvr_flag_next = lvr_flag_reg;
        warn_flag_next = warn_flag_reg;
        irq_en_next = irq_en_reg;
        pend_next = pend_reg;
        // Reads, writes and the warning copy stop in halt; flags still follow events in wait.
        if (!halt_mode_in)
        begin
            if (status_rd_in)
            begin
                wdg_flag_next = 1'b0;
                lvr_flag_next = 1'b0;
            end
            if (wdg_flag_wr0_in)
            begin
                wdg_flag_next = 1'b0;
            end
            if (irq_enable_wr_in)
            begin
                irq_en_next = irq_enable_data_in;
            end
            // Real-time copy of the comparator, only with the detector on.
            warn_flag_next = lv_detector_en_in && warn_sync;
        end
        // Set wins over clear; the low-voltage reset clears the watchdog flag.
        if (watchdog_underflow_in)
        begin
            wdg_flag_next = 1'b1;
        end
        if (lv_req)
        begin
            lvr_flag_next = 1'b1;
            wdg_flag_next = 1'b0;
        end
        // Request latches on a rising flag while enabled, clears on entry.
        if (irq_ack_in)
        begin
            pend_next = 1'b0;
        end
        if (warn_flag_next && !warn_flag_reg && irq_en_next)
        begin
            pend_next = 1'b1;
        end
        irq_next = pend_next && irq_en_next && !cc_irq_mask_in;
        wake_next = pend_next && irq_en_next && wait_mode_in && !halt_mode_in;
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // All state held under the asynchronous reset.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= RSS_ST_ACTIVE;
            dly_reg <= '0;
            wpulse_reg <= '0;
            faddr_reg <= RESET_VEC_HI_ADDR;
            wdg_flag_reg <= FLAG_RST_VAL;
            lvr_flag_reg <= FLAG_RST_VAL;
            warn_flag_reg <= FLAG_RST_VAL;
            irq_en_reg <= FLAG_RST_VAL;
            pend_reg <= FLAG_RST_VAL;
            pin_oe_reg <= 1'b1;
            core_rst_reg <= 1'b1;
            fa_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            dly_reg <= dly_next;
            wpulse_reg <= wpulse_next;
            faddr_reg <= faddr_next;
            wdg_flag_reg <= wdg_flag_next;
            lvr_flag_reg <= lvr_flag_next;
            warn_flag_reg <= warn_flag_next;
            irq_en_reg <= irq_en_next;
            pend_reg <= pend_next;
            pin_oe_reg <= pin_oe_next;
            core_rst_reg <= core_rst_next;
            fa_reg <= fa_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
        end
    end

    // Threshold level passed to the analog detector.
    logic [1:0] lv_level_reg;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lv_level_reg <= RSS_LV_LOW;
        end
        else
        begin
            lv_level_reg <= lv_level_in;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Open-drain: the data is always low, only the enable moves.
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = pin_oe_reg;
    assign core_reset_out = core_rst_reg;
    assign fetch_active_out = fa_reg;
    assign fetch_addr_out = faddr_reg;
    assign status_out = {3'h0, wdg_flag_reg, 1'b0, lvr_flag_reg, warn_flag_reg,
        irq_en_reg};
    assign irq_out = irq_reg;
    assign wake_out = wake_reg;
    assign lv_level_out = lv_level_reg;

endmodule
`default_nettype wire

// ==== testbench/rss_reset_sequence_manager_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker for the reset sequencer
// ************************************************************
module rss_monitor
    import rss_pkg::*;
#(
    parameter int unsigned STAB_LONG = STAB_LONG_CYC,
    parameter int unsigned PLL_STARTUP = PLL_STARTUP_DELAY_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic low_voltage_below_in,
    input wire logic warn_below_in,
    input wire logic lv_detector_en_in,
    input wire logic [1:0] clk_src_in,
    input wire logic pll_en_in,
    input wire logic watchdog_underflow_in,
    input wire logic halt_mode_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_out,
    input wire logic core_reset_out,
    input wire logic fetch_active_out,
    input wire logic [15:0] fetch_addr_out,
    input wire logic [7:0] status_out,
    input wire logic irq_out
);
    // Length of the current run of pin drive, saturating.
    logic [15:0] run_reg;
    logic [15:0] run_next;
    // Least drive run expected before a fetch for this clock setup.
    logic [15:0] min_run;

    // Counts consecutive cycles with the pin driven.
    always_comb
    begin
        run_next = reset_pin_oe_out ? run_reg + 16'h0001 : 16'h0000;
        if (run_reg == 16'hFFFF)
            run_next = run_reg;
        min_run = 16'(clk_src_in == 2'b10 ? STAB_LONG : STAB_SHORT_CYC);
        if (pll_en_in)
            min_run = min_run + 16'(PLL_STARTUP);
    end

    // Registers the run count; reset clears it.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            run_reg <= 16'h0000;
        else
            run_reg <= run_next;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_pin_data_low: assert property (reset_pin_out == 1'b0)
        else $error("reset pin data not low");
    a_fetch_two_cycles: assert property ($rose(fetch_active_out) |->
        fetch_active_out ##1 fetch_active_out ##1 !fetch_active_out)
        else $error("fetch phase not two cycles");
    a_fetch_addr_order: assert property ($rose(fetch_active_out) |->
        fetch_addr_out == 16'hFFFE ##1 fetch_addr_out == 16'hFFFF)
        else $error("vector fetch addresses wrong");
    a_delay_drives_pin: assert property ($rose(fetch_active_out) |->
        $past(reset_pin_oe_out))
        else $error("pin not driven up to fetch");
    a_stab_length: assert property ($rose(fetch_active_out) |-> run_reg >= min_run)
        else $error("delay phase too short");
    a_core_reset_end: assert property ($fell(core_reset_out) |-> $past(fetch_active_out))
        else $error("core reset left without fetch");
    a_wdg_pulse_out: assert property (watchdog_underflow_in && !core_reset_out |->
        ##[1:2] reset_pin_oe_out [*5])
        else $error("watchdog pulse too short");
    a_low_supply_hold: assert property ((lv_detector_en_in && low_voltage_below_in) [*8] |->
        reset_pin_oe_out)
        else $error("low supply without reset");
    a_warn_flag_track: assert property (
        (lv_detector_en_in && warn_below_in && !halt_mode_in) [*5] |-> status_out[1])
        else $error("warning flag not set");
    a_irq_needs_flag: assert property ($rose(irq_out) |-> status_out[1] && status_out[0])
        else $error("interrupt without flag and enable");

    c_fetch: cover property ($rose(fetch_active_out));
    c_irq: cover property ($rose(irq_out));
    c_wdg: cover property (watchdog_underflow_in && !core_reset_out);
endmodule
bind rss_reset_sequence_manager rss_monitor #(
    .STAB_LONG(STAB_LONG),
    .PLL_STARTUP(PLL_STARTUP)
) u_mon (.*);
`default_nettype wire

// ==== testbench/rss_board_reset.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Board reset circuit: power-up hold and push-button pulse
// ************************************************************
module rss_board_reset #(
    parameter int unsigned PULSE_CYC = 3
) (
    input wire logic clk_in,
    input wire logic hold_in,
    input wire logic press_in,
    input wire logic dev_oe_in,
    output logic pin_n_out
);
    // Cycles of button pulse still to run.
    logic [7:0] cnt_reg = 8'h00;
    logic [7:0] cnt_next;

    // A press loads the full width so the pulse is never short.
    always_comb
    begin
        cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        if (press_in)
            cnt_next = 8'(PULSE_CYC);
    end

    // Registers the pulse count.
    always_ff @(posedge clk_in)
    begin
        cnt_reg <= cnt_next;
    end

    // Open drain with pull-up: any party pulling low wins, else the line rises.
    assign pin_n_out = !(hold_in || cnt_reg != 8'h00 || dev_oe_in);
endmodule
`default_nettype wire

// ==== testbench/tb_rss_reset_sequence_manager.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_rss_reset_sequence_manager;
    import rss_pkg::*;
    localparam int unsigned SL = 300; // Shortened crystal delay.
    localparam int unsigned PS = 4; // Shortened PLL wait.
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic pin_w, pin_o, oe, core, fa, irq, wake;
    logic lvb = 1'b0, wb = 1'b0, lven = 1'b1, pll = 1'b0;
    logic halt = 1'b0, waitm = 1'b0, mask = 1'b0, ied = 1'b0, hold = 1'b1;
    // One-cycle strobes, each picked by its index below.
    logic [6:0] pls = 7'h00;
    localparam int wdg = 0, ill = 1, iew = 2, rd = 3, wr0 = 4, ack = 5, press = 6;
    logic [1:0] lvl = 2'b00, src = 2'b00, lvlo;
    logic [15:0] faddr;
    logic [7:0] st;
    int bad_count = 0;
    int samples_checked = 0;

    always #2 clk_in = ~clk_in;

    rss_board_reset u_board (.clk_in(clk_in), .hold_in(hold), .press_in(pls[press]),
        .dev_oe_in(oe), .pin_n_out(pin_w));

    rss_reset_sequence_manager #(.STAB_LONG(SL), .PLL_STARTUP(PS)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .reset_pin_n_in(pin_w), .reset_pin_out(pin_o),
        .reset_pin_oe_out(oe), .low_voltage_below_in(lvb), .warn_below_in(wb),
        .lv_detector_en_in(lven), .lv_level_in(lvl), .clk_src_in(src), .pll_en_in(pll),
        .watchdog_underflow_in(pls[wdg]), .illegal_opcode_in(pls[ill]), .halt_mode_in(halt),
        .wait_mode_in(waitm), .cc_irq_mask_in(mask), .irq_enable_wr_in(pls[iew]),
        .irq_enable_data_in(ied), .status_rd_in(pls[rd]), .wdg_flag_wr0_in(pls[wr0]),
        .irq_ack_in(pls[ack]), .lv_level_out(lvlo), .core_reset_out(core),
        .fetch_active_out(fa), .fetch_addr_out(faddr), .status_out(st),
        .irq_out(irq), .wake_out(wake));

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Moves just past the next rising edges so outputs are settled.
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Raises one strobe for a single cycle, changing it on rising edges.
    task automatic pulse(input int i);
        @(posedge clk_in);
        pls[i] <= 1'b1;
        @(posedge clk_in);
        pls[i] <= 1'b0;
        #1;
    endtask

    // Waits for the vector fetch, returns the cycles spent, checks the fetch.
    task automatic seq(output int c);
        c = 0;
        while (fa !== 1'b1 && c < 8000)
        begin
            tick();
            c++;
        end
        if (c == 8000)
        begin
            bad_count++;
            results();
        end
        check(faddr, 16'hFFFE);
        tick();
        check(faddr, 16'hFFFF);
        tick(2);
        check(16'(core), 16'h0000);
    endtask

    // Delay length per clock source and with the PLL.
    task automatic t_delays();
        int c[4];
        for (int k = 0; k < 4; k++)
        begin
            src <= 2'(k % 3);
            pll <= (k == 3);
            tick();
            pulse(wdg);
            seq(c[k]);
        end
        check(16'(c[1] - c[0]), 16'h0000);
        check(16'(c[2] - c[0]), 16'(SL - 256));
        check(16'(c[3] - c[0]), 16'(PS));
        pll <= 1'b0;
        src <= 2'b00;
    endtask

    // Watchdog and low-voltage flags through resets, reads and writes.
    task automatic t_flags();
        int c;
        pulse(wdg);
        seq(c);
        check(16'(st[4]), 16'h0001);
        pulse(rd);
        check(16'(st[4]), 16'h0000);
        pulse(wdg);
        seq(c);
        pulse(wr0);
        check(16'(st[4]), 16'h0000);
        pulse(wdg);
        lvb <= 1'b1;
        tick(400);
        check(16'(oe), 16'h0001);
        check(16'(pin_w), 16'h0000);
        lvb <= 1'b0;
        seq(c);
        check(16'(st[2]), 16'h0001);
        check(16'(st[4]), 16'h0000);
        pulse(wdg);
        seq(c);
        check(16'(st[2]), 16'h0001);
        pulse(rd);
        check(16'(st[2]), 16'h0000);
    endtask

    // A new request during the delay restarts the sequence.
    task automatic t_restart();
        int a, b;
        pulse(wdg);
        seq(a);
        pulse(wdg);
        tick(100);
        pulse(ill);
        seq(b);
        // The opcode source has no least pulse, so its active phase is shorter.
        check(16'(b), 16'(a - MIN_RESET_OUT_PULSE_CYC));
    endtask

    // A short pin pulse is caught while halted and the pin stays low.
    task automatic t_pin();
        int c;
        halt <= 1'b1;
        pulse(press);
        tick(10);
        check(16'(pin_w), 16'h0000);
        halt <= 1'b0;
        seq(c);
    endtask

    // Warning flag, interrupt, wake, acknowledge, halt freeze, disabled detector.
    task automatic t_warn();
        ied <= 1'b1;
        pulse(iew);
        check(16'(st[0]), 16'h0001);
        wb <= 1'b1;
        waitm <= 1'b1;
        mask <= 1'b1;
        tick(6);
        check(16'(irq), 16'h0000);
        mask <= 1'b0;
        tick(2);
        check(16'(st[1]), 16'h0001);
        check(16'(irq), 16'h0001);
        check(16'(wake), 16'h0001);
        pulse(ack);
        check(16'(irq), 16'h0000);
        check(16'(wake), 16'h0000);
        waitm <= 1'b0;
        halt <= 1'b1;
        wb <= 1'b0;
        tick(6);
        check(16'(st[1]), 16'h0001);
        halt <= 1'b0;
        tick(6);
        check(16'(st[1]), 16'h0000);
        lven <= 1'b0;
        wb <= 1'b1;
        tick(6);
        check(16'(st[1]), 16'h0000);
        wb <= 1'b0;
        lven <= 1'b1;
        tick(6);
    endtask

    // Every threshold level is carried to the output.
    task automatic t_levels();
        for (int k = 0; k < 3; k++)
        begin
            lvl <= 2'(k);
            tick(2);
            check(16'(lvlo), 16'(k));
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence: power-up under the board hold, then each scenario.
    initial
    begin
        int c;
        tick(5);
        rst_in <= 1'b0;
        hold <= 1'b0;
        seq(c);
        t_delays();
        t_flags();
        t_restart();
        t_pin();
        t_warn();
        t_levels();
        results();
    end
endmodule
`default_nettype wire
